// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// testbench for the global interrupt enable block
// ********************************************************************
module tb_top;
  import ugie_pkg::*;

  localparam logic [31:0] BOTH_M = 32'hd020_001e;
  localparam logic [31:0] HOST_M = 32'h0700_0020;
  localparam logic [31:0] DEV_M  = 32'h201c_fcc0;
  localparam logic [31:0] WR_M   = 32'hf73c_fcfe;

  logic        clk;
  logic        nrst;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] flag_set;
  logic        current_role;
  logic        irq_q;
  logic [31:0] rd;
  logic [31:0] m;
  int          error_cnt;
  int          cmp_count;

  ugie_core i_ugie_core (
    .clk             (clk),
    .nrst            (nrst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .flag_set        (flag_set),
    .current_role    (current_role),
    .irq_q           (irq_q)
  );

  // ******************************************************************
  // clock, tasks
  // ******************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, 4'hf, q);
  endtask

  task automatic pulse(input logic [31:0] v);
    @(posedge clk);
    flag_set <= v;
    @(posedge clk);
    flag_set <= 32'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  // ******************************************************************
  // tests
  // ******************************************************************
  initial begin
    nrst = 1'b0; avs_address = 12'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h0; flag_set = 32'h0;
    current_role = 1'b0; error_cnt = 0; cmp_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    bus_xfer(1'b0, ENABLE_OFS, 32'h0, 4'hf, rd);
    check("enable reset", rd, 32'h0);
    check("irq reset", {31'h0, irq_q}, 32'h0);
    wr32(ENABLE_OFS, WR_M);
    bus_xfer(1'b0, ENABLE_OFS, 32'h0, 4'hf, rd);
    check("enable rw", rd, WR_M);
    $display("test reset_rw done");

    for (int r = 0; r < 2; r++) begin
      current_role <= r[0];
      // role groups: both, host
      // device
      m = BOTH_M | (r[0] ? HOST_M : DEV_M);
      for (int b = 1; b < 32; b++) begin
        if (WR_M[b]) begin
          wr32(ENABLE_OFS, WR_M & ~(32'h1 << b));
          wr32(FLAGS_OFS, 32'hffff_ffff);
          pulse(32'h1 << b);
          check("irq masked", {31'h0, irq_q}, 32'h0);
          bus_xfer(1'b0, FLAGS_OFS, 32'h0, 4'hf, rd);
          check("flag set", {31'h0, rd[b]}, 32'h1);
          check("role bit", {31'h0, rd[0]}, r);
          wr32(ENABLE_OFS, 32'h1 << b);
          repeat (3) @(posedge clk);
          check("irq gate", {31'h0, irq_q}, {31'h0, m[b]});
        end
      end
    end
    $display("test per_bit done");

    current_role <= 1'b0;
    wr32(ENABLE_OFS, 32'h2);
    wr32(FLAGS_OFS, 32'hffff_ffff);
    bus_xfer(1'b0, 12'h100, 32'h0, 4'hf, rd);
    check("unmapped read", rd, 32'h0);
    repeat (3) @(posedge clk);
    check("no fault irq", {31'h0, irq_q}, 32'h0);
    bus_xfer(1'b0, HOST_WIN_LO, 32'h0, 4'hf, rd);
    check("fault read", rd, 32'h0);
    repeat (3) @(posedge clk);
    check("fault irq dev", {31'h0, irq_q}, 32'h1);
    current_role <= 1'b1;
    wr32(FLAGS_OFS, 32'hffff_ffff);
    wr32(DEV_WIN_LO, 32'hffff_ffff);
    bus_xfer(1'b0, FLAGS_OFS, 32'h0, 4'hf, rd);
    check("fault flag host", rd[1:0], 2'b11);
    bus_xfer(1'b0, ENABLE_OFS, 32'h0, 4'hf, rd);
    check("enable kept", rd, 32'h2);
    $display("test mode_fault done");

    wr32(ENABLE_OFS, 32'h0);
    bus_xfer(1'b1, ENABLE_OFS, WR_M, 4'b0010, rd);
    bus_xfer(1'b0, ENABLE_OFS, 32'h0, 4'hf, rd);
    check("lane write", rd, 32'h0000_fc00);
    flag_set <= 32'h0000_0010;
    wr32(FLAGS_OFS, 32'hffff_ffff);
    flag_set <= 32'h0;
    bus_xfer(1'b0, FLAGS_OFS, 32'h0, 4'hf, rd);
    check("set wins", {31'h0, rd[4]}, 32'h1);
    $display("test lanes done");

    wr32(ENABLE_OFS, WR_M);
    pulse(32'h0000_0010);
    check("irq before reset", {31'h0, irq_q}, 32'h1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq in reset", {31'h0, irq_q}, 32'h0);
    nrst <= 1'b1;
    bus_xfer(1'b0, ENABLE_OFS, 32'h0, 4'hf, rd);
    check("enable rereset", rd, 32'h0);
    $display("test second_reset done");
    summarize();
  end

endmodule // tb_top
`default_nettype wire

// file: ugie_core.sv
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ugie_core
  import ugie_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic [ugie_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [ugie_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [ugie_pkg::BE_W-1:0]   avs_byteenable,
  output logic [ugie_pkg::DATA_W-1:0]      avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [31:0]               flag_set,
  input  wire logic                      current_role,
  output logic                           irq_q
);
  import ugie_pkg::*;

  // ******************************************************************
  // state
  // ******************************************************************
  logic [31:0] enable_q;
  logic [31:0] flags_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        req;
  logic        commit;
  logic        hit_enable;
  logic        hit_flags;
  logic        hit_host_win;
  logic        hit_dev_win;
  logic        wrong_role;
  logic [31:0] wmask;
  logic [31:0] flags_set_d;
  logic [31:0] flags_clr_d;
  logic [31:0] flags_view;
  logic [31:0] rdata_d;

  // ******************************************************************
  // address decode
  // ******************************************************************
  always_comb begin
    req          = avs_read | avs_write;
    commit       = req & ~wait_q;
    hit_enable   = (avs_address == ENABLE_OFS);
    hit_flags    = (avs_address == FLAGS_OFS);
    hit_host_win = (avs_address >= HOST_WIN_LO) && (avs_address <= HOST_WIN_HI);
    hit_dev_win  = (avs_address >= DEV_WIN_LO) && (avs_address <= DEV_WIN_HI);
    wrong_role   = (hit_host_win && (current_role == ROLE_DEVICE)) ||
                   (hit_dev_win && (current_role == ROLE_HOST));
    wmask        = lane_mask(avs_byteenable);
  end

  // ******************************************************************
  // bus handshake: one wait cycle, then one answer cycle
  // ******************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  // ******************************************************************
  // read path
  // ******************************************************************
  always_comb begin
    flags_view = flags_q;
    flags_view[CURRENT_ROLE_BIT] = current_role;
    rdata_d = 32'h0000_0000;
    if (avs_read && wait_q) begin
      if (hit_enable) begin
        rdata_d = enable_q;
      end else if (hit_flags) begin
        rdata_d = flags_view;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ******************************************************************
  // enable register
  // ******************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable_q <= ENABLE_RST;
    end else if (commit && avs_write && hit_enable) begin
      // reserved bits stay zero
      enable_q <= (enable_q & ~(wmask & WRITABLE_MASK)) |
                  (avs_writedata & wmask & WRITABLE_MASK);
    end
  end

  // ******************************************************************
  // flag register: events set, write one clears, set wins
  // ******************************************************************
  always_comb begin
    flags_set_d = flag_set & WRITABLE_MASK;
    if (commit && wrong_role) begin
      flags_set_d[MODE_FAULT_BIT] = 1'b1;
    end
    flags_clr_d = 32'h0000_0000;
    if (commit && avs_write && hit_flags) begin
      flags_clr_d = avs_writedata & wmask & WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~flags_clr_d) | flags_set_d;
    end
  end

  // ******************************************************************
  // interrupt request
  // ******************************************************************
  // role groups
  ugie_irq_gate u_gate (
    .clk          (clk),
    .nrst         (nrst),
    .flags        (flags_q),
    .enable       (enable_q),
    .current_role (current_role),
    .irq_q        (irq_q)
  );

  // ******************************************************************
  // outputs
  // ******************************************************************
  always_comb begin
    avs_waitrequest = wait_q;
    avs_readdata    = rdata_q;
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  logic [31:0] live_en;
  logic        seen_wr_q;

  always_comb begin
    live_en = enable_q & role_mask(current_role);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_wr_q <= 1'b0;
    end else if (commit && avs_write && hit_enable) begin
      seen_wr_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  reset_zero_a: assert property (
    !seen_wr_q |-> (enable_q == 32'h0000_0000)
  ) else $error("enable not zero before first write");

  reserved_zero_a: assert property (
    (enable_q & ~WRITABLE_MASK) == 32'h0000_0000
  ) else $error("reserved enable bit set");

  enable_write_a: assert property (
    (commit && avs_write && hit_enable && avs_byteenable == 4'hf)
      |=> (enable_q == ($past(avs_writedata) & WRITABLE_MASK))
  ) else $error("enable write not stored");

  masked_quiet_a: assert property (
    ((flags_q & live_en) == 32'h0000_0000) |=> !irq_q
  ) else $error("request raised by masked flag");

  irq_raise_a: assert property (
    ((flags_q & live_en) != 32'h0000_0000) |=> irq_q
  ) else $error("request missing for enabled flag");

  flag_set_a: assert property (
    ((flag_set & WRITABLE_MASK) != 32'h0000_0000)
      |=> ((flags_q & $past(flag_set & WRITABLE_MASK))
           == $past(flag_set & WRITABLE_MASK))
  ) else $error("event lost from flag register");

  host_gate_a: assert property (
    ((current_role == ROLE_DEVICE) &&
     ((flags_q & enable_q & ~HOST_ONLY_MASK) == 32'h0000_0000)) |=> !irq_q
  ) else $error("host enable live in device role");

  dev_gate_a: assert property (
    ((current_role == ROLE_HOST) &&
     ((flags_q & enable_q & ~DEVICE_ONLY_MASK) == 32'h0000_0000)) |=> !irq_q
  ) else $error("device enable live in host role");

  mode_fault_a: assert property (
    (commit && wrong_role) |=> flags_q[MODE_FAULT_BIT]
  ) else $error("mode fault not flagged");

  wake_session_a: assert property (
    ((flags_q[WAKEUP_IRQ_EN_BIT] && enable_q[WAKEUP_IRQ_EN_BIT]) ||
     (flags_q[SESSION_IRQ_EN_BIT] && enable_q[SESSION_IRQ_EN_BIT])) |=> irq_q
  ) else $error("wakeup or session request missing");

  id_pin_a: assert property (
    (flags_q[ID_PIN_IRQ_EN_BIT] && enable_q[ID_PIN_IRQ_EN_BIT]) |=> irq_q
  ) else $error("id pin request missing");

  shared_bit_a: assert property (
    (flags_q[PERIODIC_INC_IRQ_EN_BIT] && enable_q[PERIODIC_INC_IRQ_EN_BIT]) |=> irq_q
  ) else $error("incomplete transfer request missing");

  iso_in_a: assert property (
    ((current_role == ROLE_DEVICE) && flags_q[ISO_IN_INC_IRQ_EN_BIT] &&
     enable_q[ISO_IN_INC_IRQ_EN_BIT]) |=> irq_q
  ) else $error("iso in request missing in device role");

  np_fifo_a: assert property (
    ((current_role == ROLE_HOST) && flags_q[NP_TXF_IRQ_EN_BIT] &&
     enable_q[NP_TXF_IRQ_EN_BIT]) |=> irq_q
  ) else $error("tx fifo request missing in host role");

  enable_read_a: assert property (
    (avs_read && wait_q && hit_enable) |=> (avs_readdata == $past(enable_q))
  ) else $error("enable read data wrong");

  idle_wait_a: assert property (
    !req |=> avs_waitrequest
  ) else $error("bus answered without request");

  role_read_a: assert property (
    (avs_read && wait_q && hit_flags)
      |=> (avs_readdata[CURRENT_ROLE_BIT] == $past(current_role))
  ) else $error("role bit misread");

  bus_answer_a: assert property (
    (req && wait_q) |=> !avs_waitrequest ##1 avs_waitrequest
  ) else $error("bus answer not in one cycle");

  irq_cover_c: cover property ($rose(irq_q));
  fault_cover_c: cover property (commit && wrong_role);
  masked_set_c: cover property (
    (flag_set[WAKEUP_IRQ_EN_BIT] && !enable_q[WAKEUP_IRQ_EN_BIT])
  );
  set_clear_c: cover property (
    (commit && avs_write && hit_flags && ((flag_set & avs_writedata) != 32'h0))
  );

endmodule // ugie_core
`default_nettype wire

// file: ugie_irq_gate.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************************************************
// interrupt request gate
// ********************************************************************
module ugie_irq_gate
  import ugie_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] flags,
  input  wire logic [31:0] enable,
  input  wire logic        current_role,
  output logic             irq_q
);
  import ugie_pkg::*;

  logic [31:0] live_en;
  logic        irq_d;

  // role filter on the enables
  always_comb begin
    live_en = enable & role_mask(current_role);
    irq_d   = |(flags & live_en);
  end

  // one level request, refreshed each clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

endmodule // ugie_irq_gate
`default_nettype wire

// file: ugie_pkg.sv
// ********************************************************************
// constants for the global interrupt enable block
// ********************************************************************
package ugie_pkg;

  // ******************************************************************
  // bus geometry
  // ******************************************************************
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;
  localparam int          BE_W   = 4;

  // ******************************************************************
  // register offsets (byte addresses)
  // ******************************************************************
  localparam logic [11:0] FLAGS_OFS  = 12'h014;
  localparam logic [11:0] ENABLE_OFS = 12'h018;

  // host-only and device-only register windows
  localparam logic [11:0] HOST_WIN_LO = 12'h400;
  localparam logic [11:0] HOST_WIN_HI = 12'h7fc;
  localparam logic [11:0] DEV_WIN_LO  = 12'h800;
  localparam logic [11:0] DEV_WIN_HI  = 12'hbfc;

  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST  = 32'h0000_0000;

  // ******************************************************************
  // enable field positions
  // ******************************************************************
  localparam int WAKEUP_IRQ_EN_BIT       = 31;
  localparam int SESSION_IRQ_EN_BIT      = 30;
  localparam int DISCONNECT_IRQ_EN_BIT   = 29;
  localparam int ID_PIN_IRQ_EN_BIT       = 28;
  localparam int PERIODIC_TXF_IRQ_EN_BIT = 26;
  localparam int HOST_CHAN_IRQ_EN_BIT    = 25;
  localparam int HOST_PORT_IRQ_EN_BIT    = 24;
  localparam int PERIODIC_INC_IRQ_EN_BIT = 21;
  localparam int ISO_IN_INC_IRQ_EN_BIT   = 20;
  localparam int OUT_EP_IRQ_EN_BIT       = 19;
  localparam int IN_EP_IRQ_EN_BIT        = 18;
  localparam int FRAME_END_IRQ_EN_BIT    = 15;
  localparam int ISO_DROP_IRQ_EN_BIT     = 14;
  localparam int SPEED_DONE_IRQ_EN_BIT   = 13;
  localparam int BUS_RESET_IRQ_EN_BIT    = 12;
  localparam int SUSPEND_IRQ_EN_BIT      = 11;
  localparam int EARLY_SUSP_IRQ_EN_BIT   = 10;
  localparam int OUT_NAK_IRQ_EN_BIT      = 7;
  localparam int NP_IN_NAK_IRQ_EN_BIT    = 6;
  localparam int NP_TXF_IRQ_EN_BIT       = 5;
  localparam int RXF_NE_IRQ_EN_BIT       = 4;
  localparam int FRAME_START_IRQ_EN_BIT  = 3;
  localparam int DUAL_ROLE_IRQ_EN_BIT    = 2;
  localparam int MODE_FAULT_BIT          = 1;
  localparam int CURRENT_ROLE_BIT        = 0;

  // ******************************************************************
  // role groups of the enable bits
  // ******************************************************************
  localparam logic [31:0] BOTH_ROLE_MASK   = 32'hd020_001e;
  localparam logic [31:0] HOST_ONLY_MASK   = 32'h0700_0020;
  localparam logic [31:0] DEVICE_ONLY_MASK = 32'h201c_fcc0;
  localparam logic [31:0] WRITABLE_MASK    = 32'hf73c_fcfe;

  localparam logic        ROLE_DEVICE = 1'b0;
  localparam logic        ROLE_HOST   = 1'b1;

  // ******************************************************************
  // shared decoding
  // ******************************************************************
  function automatic logic [31:0] role_mask(input logic role);
    role_mask = BOTH_ROLE_MASK | (role ? HOST_ONLY_MASK : DEVICE_ONLY_MASK);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

endpackage
